/* rtl/sdstc_core.sv */
// Serial audio stream input, header parser, playback pacing and test command detector.
`timescale 1ns/1ps
// How it works
// - Tests need four command bytes plus four zeros.
// - Bytes 53 EF 6E n 0000 start sine.
// - Parameter bits 7:5 rate, 4:0 step.
// - Rate index picks rate; step/128 of rate.
// - Bytes 45 78 69 74 0000 end sine.
// - Sine passes the per-channel volume stage.
// - Nothing decodable: header words zero, outputs muted.
// - Idle state keeps watching input for data.
// - Streams follow back to back; zeros after each.
// - Length 0 or 0FFFFFFF plays until abort.
// - Eight and sixteen bit, mono or stereo.
// - ADPCM plays at any header sample rate.
// - Soft reset holds data request low 16600 cycles.
module sdstc_core #(
	parameter int SRST_HOLD_CYC = sdstc_pkg::SRST_HOLD_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Serial data link
	input wire logic serialDataClk,
	input wire logic serialDataInput,
	output logic dataRequest,
	// Audio output
	output sdstc_pkg::sdstc_audio_t audioOut,
	output logic audioMute,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int SRW = $clog2(SRST_HOLD_CYC + 1);

	// ********************************
	// Functions
	// ********************************

	function automatic logic signed [15:0] sineAt(input logic [6:0] ph);
		logic [15:0] mag;
		if (ph[5] && ph[4:0] == 5'h00) begin
			mag = sdstc_pkg::SINE_PEAK;
		end else begin
			mag = sdstc_pkg::SINE_Q[ph[5] ? 5'(5'h00 - ph[4:0]) : ph[4:0]];
		end
		return ph[6] ? -$signed(mag) : $signed(mag);
	endfunction

	function automatic logic signed [15:0] atten(input logic signed [15:0] s,
		input logic [7:0] a);
		logic signed [25:0] p;
		p = s * $signed({1'b0, 9'h100 - {1'b0, a}});
		return p[23:8];
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a == sdstc_pkg::ADDR_MODE || a == sdstc_pkg::ADDR_VOL
			|| a == sdstc_pkg::ADDR_HDAT0 || a == sdstc_pkg::ADDR_HDAT1
			|| a == sdstc_pkg::ADDR_STAT;
	endfunction

	// ********************************
	// State
	// ********************************

	logic [2:0] clkSync_q, datSync_q;
	logic clkLvl_q;
	logic [2:0] bitCnt_q;
	logic [6:0] shift_q;
	logic [7:0] hold_q;
	logic holdV_q;
	logic [SRW-1:0] srstCnt_q;
	logic srstPulse_q, testEn_q, abort_q;
	logic [15:0] vol_q;
	sdstc_pkg::sdstc_state_t state_q;
	logic [63:0] hist_q;
	logic [7:0] hdrCnt_q, bits_q, sineParam_q, loByte_q;
	logic [15:0] fmt_q;
	logic [31:0] rate_q, len_q, lenLeft_q;
	logic chan2_q, dataSeen_q, endless_q;
	logic [1:0] lenCnt_q;
	logic byteIdx_q, chIdx_q, frameFull_q;
	logic signed [15:0] smpL_q, smpR_q;
	logic [27:0] acc_q;
	logic [6:0] sinePh_q;
	logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q, rdata_q;
	logic [3:0] wStrb_q;
	logic [1:0] bresp_q, rresp_q;
	sdstc_pkg::sdstc_audio_t audio_q;

	// ********************************
	// Link receiver
	// ********************************

	wire clkAgree = clkSync_q[2] == clkSync_q[1];
	wire linkRise = clkAgree && clkSync_q[2] && !clkLvl_q;
	wire byteDone = linkRise && bitCnt_q == 3'h7;
	wire srstBusy = srstCnt_q != '0;
	wire take = holdV_q && !srstBusy && !frameFull_q;

	assign dataRequest = !holdV_q && !srstBusy && !frameFull_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			clkSync_q <= 3'h0;
			datSync_q <= 3'h0;
			clkLvl_q <= 1'b0;
		end else begin
			clkSync_q <= {clkSync_q[1:0], serialDataClk};
			datSync_q <= {datSync_q[1:0], serialDataInput};
			if (clkAgree) clkLvl_q <= clkSync_q[2];
		end
	end

	// A byte that lands as the held one is taken replaces it, so none is dropped.
	always_ff @(posedge mclk) begin
		if (srst || srstPulse_q) begin
			bitCnt_q <= 3'h0;
			shift_q <= 7'h00;
			hold_q <= 8'h00;
			holdV_q <= 1'b0;
		end else begin
			if (linkRise) begin
				bitCnt_q <= bitCnt_q + 3'h1;
				shift_q <= {shift_q[5:0], datSync_q[2]};
			end
			if (byteDone) begin
				hold_q <= {shift_q, datSync_q[2]};
				holdV_q <= 1'b1;
			end else if (take) begin
				holdV_q <= 1'b0;
			end
		end
	end

	// ********************************
	// Command detector and header parser
	// ********************************

	wire [63:0] histD = {hist_q[55:0], hold_q};
	wire tailZero = histD[31:0] == 32'h0;
	wire sineCmd = testEn_q && histD[63:40] == sdstc_pkg::CMD_SINE && tailZero;
	wire exitCmd = testEn_q && histD[63:32] == sdstc_pkg::CMD_EXIT && tailZero;
	wire riffSeen = !testEn_q && histD[31:0] == sdstc_pkg::ID_RIFF;
	wire dataIdSeen = histD[31:0] == sdstc_pkg::ID_DATA && hdrCnt_q >= sdstc_pkg::OFS_SEARCH;
	wire [31:0] lenD = {hold_q, len_q[31:8]};
	wire bits16 = bits_q == sdstc_pkg::BITS_16;
	wire pcmOk = fmt_q == sdstc_pkg::FMT_PCM && (bits16 || bits_q == sdstc_pkg::BITS_8);
	wire fmtOk = pcmOk || fmt_q == sdstc_pkg::FMT_ADPCM;
	wire inStream = state_q == sdstc_pkg::ST_PLAY || state_q == sdstc_pkg::ST_HDR;
	wire abortNow = abort_q && inStream;

	always_ff @(posedge mclk) begin
		if (srst || srstPulse_q) begin
			state_q <= sdstc_pkg::ST_IDLE;
			hist_q <= 64'h0;
			hdrCnt_q <= 8'h00;
			fmt_q <= 16'h0000;
			bits_q <= 8'h00;
			rate_q <= 32'h0;
			len_q <= 32'h0;
			lenLeft_q <= 32'h0;
			chan2_q <= 1'b0;
			dataSeen_q <= 1'b0;
			endless_q <= 1'b0;
			lenCnt_q <= 2'h0;
			sineParam_q <= 8'h00;
		end else if (abortNow) begin
			state_q <= sdstc_pkg::ST_IDLE;
		end else if (take) begin
			hist_q <= histD;
			case (state_q)
				sdstc_pkg::ST_IDLE: begin
					if (sineCmd) begin
						state_q <= sdstc_pkg::ST_SINE;
						sineParam_q <= histD[39:32];
					end else if (riffSeen) begin
						state_q <= sdstc_pkg::ST_HDR;
						hdrCnt_q <= sdstc_pkg::HDR_START;
						dataSeen_q <= 1'b0;
						lenCnt_q <= 2'h0;
					end
				end
				sdstc_pkg::ST_HDR: begin
					hdrCnt_q <= hdrCnt_q + 8'h01;
					if (hdrCnt_q == sdstc_pkg::OFS_FMT || hdrCnt_q == sdstc_pkg::OFS_FMT + 8'h01)
						fmt_q <= {hold_q, fmt_q[15:8]};
					if (hdrCnt_q == sdstc_pkg::OFS_CHAN)
						chan2_q <= hold_q == sdstc_pkg::CHAN_STEREO;
					if (hdrCnt_q >= sdstc_pkg::OFS_RATE && hdrCnt_q < sdstc_pkg::OFS_RATE + 8'h04)
						rate_q <= {hold_q, rate_q[31:8]};
					if (hdrCnt_q == sdstc_pkg::OFS_BITS)
						bits_q <= hold_q;
					if (dataSeen_q) begin
						len_q <= lenD;
						lenCnt_q <= lenCnt_q + 2'h1;
						if (lenCnt_q == 2'h3) begin
							state_q <= fmtOk ? sdstc_pkg::ST_PLAY : sdstc_pkg::ST_IDLE;
							lenLeft_q <= lenD;
							endless_q <= lenD == 32'h0 || lenD == sdstc_pkg::LEN_ENDLESS;
						end
					end else if (dataIdSeen) begin
						dataSeen_q <= 1'b1;
					end else if (hdrCnt_q == sdstc_pkg::HDR_MAX) begin
						state_q <= sdstc_pkg::ST_IDLE;
					end
				end
				sdstc_pkg::ST_PLAY: begin
					if (!endless_q) begin
						lenLeft_q <= lenLeft_q - 32'h1;
						if (lenLeft_q == 32'h1) state_q <= sdstc_pkg::ST_IDLE;
					end
				end
				sdstc_pkg::ST_SINE: begin
					if (exitCmd) state_q <= sdstc_pkg::ST_IDLE;
				end
				default: begin
					state_q <= sdstc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ********************************
	// Sample assembly and pacing
	// ********************************

	wire playing = state_q == sdstc_pkg::ST_PLAY;
	wire smpDone = !bits16 || byteIdx_q;
	wire signed [15:0] smpWord = bits16 ? {hold_q, loByte_q} : {~hold_q[7], hold_q[6:0], 8'h00};
	wire [19:0] rateSel = state_q == sdstc_pkg::ST_SINE
		? sdstc_pkg::RATE_TBL[sineParam_q[7:5]] : rate_q[19:0];
	wire [27:0] accSum = acc_q + {8'h00, rateSel};
	wire tick = accSum >= sdstc_pkg::CLK_HZ;
	wire signed [15:0] sineVal = sineAt(sinePh_q);

	// Mono copies one word to both channels; stereo pairs left then right.
	always_ff @(posedge mclk) begin
		if (srst || srstPulse_q || abortNow || state_q == sdstc_pkg::ST_HDR) begin
			byteIdx_q <= 1'b0;
			chIdx_q <= 1'b0;
			frameFull_q <= 1'b0;
			loByte_q <= 8'h00;
		end else if (tick && frameFull_q) begin
			frameFull_q <= 1'b0;
		end else if (take && playing) begin
			byteIdx_q <= bits16 && !byteIdx_q;
			loByte_q <= hold_q;
			if (smpDone && chan2_q && !chIdx_q) begin
				chIdx_q <= 1'b1;
			end else if (smpDone) begin
				chIdx_q <= 1'b0;
				frameFull_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			smpL_q <= 16'sh0000;
			smpR_q <= 16'sh0000;
		end else if (take && playing && smpDone) begin
			if (!chan2_q || !chIdx_q) smpL_q <= smpWord;
			if (!chan2_q || chIdx_q) smpR_q <= smpWord;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			acc_q <= 28'h0;
			sinePh_q <= 7'h00;
		end else begin
			acc_q <= tick ? accSum - sdstc_pkg::CLK_HZ : accSum;
			if (state_q != sdstc_pkg::ST_SINE) sinePh_q <= 7'h00;
			else if (tick) sinePh_q <= sinePh_q + {2'h0, sineParam_q[4:0]};
		end
	end

	// ********************************
	// Volume stage and output
	// ********************************

	assign audioMute = !frameFull_q && !playing && state_q != sdstc_pkg::ST_SINE;
	assign audioOut = audio_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			audio_q <= '0;
		end else begin
			audio_q.strobe <= 1'b0;
			if (tick && state_q == sdstc_pkg::ST_SINE) begin
				audio_q.left <= atten(sineVal, vol_q[15:8]);
				audio_q.right <= atten(sineVal, vol_q[7:0]);
				audio_q.strobe <= 1'b1;
			end else if (tick && frameFull_q) begin
				audio_q.left <= atten(smpL_q, vol_q[15:8]);
				audio_q.right <= atten(smpR_q, vol_q[7:0]);
				audio_q.strobe <= 1'b1;
			end else if (audioMute) begin
				audio_q.left <= 16'sh0000;
				audio_q.right <= 16'sh0000;
			end
		end
	end

	// ********************************
	// Register slave
	// ********************************

	wire doWrite = awHeld_q && wHeld_q && !bvalid_q;
	wire wrMode = doWrite && awAddr_q == sdstc_pkg::ADDR_MODE && wStrb_q[0];
	wire wrVol = doWrite && awAddr_q == sdstc_pkg::ADDR_VOL;
	wire sdstc_pkg::sdstc_mode_t modeIn = wData_q[2:0];
	wire [15:0] hdat0 = playing ? rate_q[15:0] : 16'h0000;
	wire [15:0] hdat1 = playing ? fmt_q : 16'h0000;
	logic [31:0] rdWord;

	always_comb begin
		if (s_axi_araddr == sdstc_pkg::ADDR_MODE) rdWord = {29'h0, srstBusy, abort_q, testEn_q};
		else if (s_axi_araddr == sdstc_pkg::ADDR_VOL) rdWord = {16'h0, vol_q};
		else if (s_axi_araddr == sdstc_pkg::ADDR_HDAT0) rdWord = {16'h0, hdat0};
		else if (s_axi_araddr == sdstc_pkg::ADDR_HDAT1) rdWord = {16'h0, hdat1};
		else if (s_axi_araddr == sdstc_pkg::ADDR_STAT)
			rdWord = {16'h0, sineParam_q, 3'h0, frameFull_q, state_q};
		else rdWord = 32'h0;
	end

	assign s_axi_awready = !awHeld_q && !bvalid_q;
	assign s_axi_wready = !wHeld_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			bvalid_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0;
			wStrb_q <= 4'h0;
			bresp_q <= sdstc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= mapped(awAddr_q) ? sdstc_pkg::RESP_OKAY : sdstc_pkg::RESP_DECERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= sdstc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rdWord;
			rresp_q <= mapped(s_axi_araddr) ? sdstc_pkg::RESP_OKAY : sdstc_pkg::RESP_DECERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// The abort bit clears itself once no stream is left to stop; a write that sets it wins.
	always_ff @(posedge mclk) begin
		if (srst) begin
			srstPulse_q <= 1'b0;
			testEn_q <= 1'b0;
			abort_q <= 1'b0;
			vol_q <= sdstc_pkg::VOL_RESET;
			srstCnt_q <= '0;
		end else begin
			srstPulse_q <= wrMode && modeIn.softReset;
			if (wrMode) testEn_q <= modeIn.testModeEnable;
			if (wrMode && modeIn.wavAbortRequest) abort_q <= 1'b1;
			else if (abortNow || !inStream) abort_q <= 1'b0;
			if (wrVol && wStrb_q[0]) vol_q[7:0] <= wData_q[7:0];
			if (wrVol && wStrb_q[1]) vol_q[15:8] <= wData_q[15:8];
			if (srstPulse_q) srstCnt_q <= SRW'(SRST_HOLD_CYC);
			else if (srstBusy) srstCnt_q <= srstCnt_q - SRW'(1);
		end
	end
endmodule

/* rtl/sdstc_pkg.sv */
// Constants and types shared by the serial stream and test command block.
package sdstc_pkg;
	localparam logic [27:0] CLK_HZ = 28'hee6b280;
	localparam int SRST_HOLD_CYC = 16600;
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_VOL = 8'h04;
	localparam logic [7:0] ADDR_HDAT0 = 8'h08;
	localparam logic [7:0] ADDR_HDAT1 = 8'h0c;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam logic [15:0] VOL_RESET = 16'h0000;
	localparam logic [23:0] CMD_SINE = 24'h53ef6e;
	localparam logic [31:0] CMD_EXIT = 32'h45786974;
	localparam logic [31:0] ID_RIFF = 32'h52494646;
	localparam logic [31:0] ID_DATA = 32'h64617461;
	localparam logic [31:0] LEN_ENDLESS = 32'h0fffffff;
	localparam logic [15:0] FMT_PCM = 16'h0001;
	localparam logic [15:0] FMT_ADPCM = 16'h0011;
	localparam logic [7:0] BITS_8 = 8'h08;
	localparam logic [7:0] BITS_16 = 8'h10;
	localparam logic [7:0] CHAN_STEREO = 8'h02;
	localparam logic [7:0] HDR_START = 8'h04;
	localparam logic [7:0] OFS_FMT = 8'h14;
	localparam logic [7:0] OFS_CHAN = 8'h16;
	localparam logic [7:0] OFS_RATE = 8'h18;
	localparam logic [7:0] OFS_BITS = 8'h22;
	localparam logic [7:0] OFS_SEARCH = 8'h24;
	localparam logic [7:0] HDR_MAX = 8'hff;
	localparam logic [19:0] RATE_TBL [8] = '{20'h0ac44, 20'h0bb80, 20'h07d00, 20'h05622,
		20'h05dc0, 20'h03e80, 20'h02b11, 20'h02ee0};
	localparam logic [15:0] SINE_PEAK = 16'h7fff;
	localparam logic [15:0] SINE_Q [32] = '{16'h0000, 16'h0648, 16'h0c8c, 16'h12c8,
		16'h18f9, 16'h1f1a, 16'h2528, 16'h2b1f, 16'h30fb, 16'h36ba, 16'h3c56, 16'h41ce,
		16'h471c, 16'h4c3f, 16'h5133, 16'h55f5, 16'h5a82, 16'h5ed7, 16'h62f1, 16'h66cf,
		16'h6a6d, 16'h6dc9, 16'h70e2, 16'h73b5, 16'h7641, 16'h7884, 16'h7a7c, 16'h7c29,
		16'h7d89, 16'h7e9c, 16'h7f61, 16'h7fd8};

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_HDR = 4'b0010,
		ST_PLAY = 4'b0100,
		ST_SINE = 4'b1000
	} sdstc_state_t;

	typedef struct packed {
		logic signed [15:0] left;
		logic signed [15:0] right;
		logic strobe;
	} sdstc_audio_t;

	typedef struct packed {
		logic softReset;
		logic wavAbortRequest;
		logic testModeEnable;
	} sdstc_mode_t;
endpackage

/* verif/sdstc_chk.sv */
// Bus and timing checks for the serial stream block.
`timescale 1ns/1ps
module sdstc_chk #(
	parameter int SRST_HOLD_CYC = sdstc_pkg::SRST_HOLD_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Observed signals
	input wire logic dataRequest,
	input wire sdstc_pkg::sdstc_audio_t audioOut,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ****
	// Checks
	// ****
	logic armed_q;
	logic [31:0] lowCnt_q;
	logic srstWr;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	assign srstWr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr == sdstc_pkg::ADDR_MODE && s_axi_wdata[2];
	always_ff @(posedge mclk) begin
		if (srst) begin
			armed_q <= 1'b0;
			lowCnt_q <= 32'h0;
		end else begin
			armed_q <= srstWr || (armed_q && !(dataRequest && lowCnt_q != 32'h0));
			lowCnt_q <= dataRequest ? 32'h0 : lowCnt_q + 32'h1;
		end
	end
	a_wr_answer: assert property (wrTaken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_rd_answer: assert property (rdTaken |=> s_axi_rvalid)
		else $error("read response late");
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken early");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken early");
	a_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == sdstc_pkg::RESP_DECERR
		|-> s_axi_rdata == 32'h0) else $error("unmapped read data not zero");
	a_strobe_pulse: assert property (audioOut.strobe |=> !audioOut.strobe)
		else $error("sample strobe too long");
	a_srst_hold: assert property (armed_q && dataRequest && lowCnt_q != 32'h0 |->
		lowCnt_q >= SRST_HOLD_CYC) else $error("request back too soon");
endmodule
bind sdstc_core sdstc_chk #(.SRST_HOLD_CYC(SRST_HOLD_CYC)) i_sdstc_chk (.mclk, .srst,
	.dataRequest, .audioOut, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready);

/* verif/sdstc_core_tb.sv */
// Self-checking bench for the serial stream and test command block.
`timescale 1ns/1ps
module sdstc_core_tb;
	// ****
	// Bench
	// ****
	logic mclk, srst, serialDataClk, serialDataInput, dataRequest, audioMute;
	sdstc_pkg::sdstc_audio_t audioOut;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	int miscompares = 0;
	int testsRun = 0;
	// Short soft reset hold so the bench stays quick.
	localparam int HOLD_SIM = 64;
	sdstc_core #(.SRST_HOLD_CYC(HOLD_SIM)) i_sdstc_core (.mclk, .srst, .serialDataClk,
		.serialDataInput, .dataRequest, .audioOut, .audioMute, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	sdstc_host i_host (.mclk, .dataRequest, .serialDataClk, .serialDataInput);
	always #2 mclk = ~mclk;
	task automatic conclude();
		if (miscompares == 0 && testsRun > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		testsRun++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tr;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge mclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tr = s_axi_bvalid;
			@(posedge mclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tr);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axiRd(input logic [7:0] a);
		logic ta, tr;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge mclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge mclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tr);
		s_axi_rready <= 1'b0;
	endtask
	task automatic sendCmd(input logic [63:0] c);
		for (int i = 7; i >= 0; i--) i_host.sendByte(c[i*8+:8]);
	endtask
	task automatic waitStrobe();
		do @(negedge mclk); while (audioOut.strobe !== 1'b1);
	endtask
	task automatic sendHdr(input logic [15:0] f, input logic [7:0] c, input logic [15:0] r,
		input logic [7:0] b);
		logic [7:0] h [44];
		h = '{8'h52, 8'h49, 8'h46, 8'h46, 8'h0, 8'h0, 8'h0, 8'h0, 8'h57, 8'h41, 8'h56, 8'h45,
			8'h66, 8'h6d, 8'h74, 8'h20, 8'h10, 8'h0, 8'h0, 8'h0, f[7:0], f[15:8], c, 8'h0,
			r[7:0], r[15:8], 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, b, 8'h0,
			8'h64, 8'h61, 8'h74, 8'h61, 8'h0, 8'h0, 8'h0, 8'h0};
		foreach (h[i]) i_host.sendByte(h[i]);
	endtask
	task automatic tRegs();
		axiRd(8'h14);
		chk("unmapped resp", {30'h0, rs}, {30'h0, sdstc_pkg::RESP_DECERR});
		axiWr(sdstc_pkg::ADDR_HDAT0, 32'h0000ffff);
		axiRd(sdstc_pkg::ADDR_HDAT0);
		chk("hdat0", rd, 32'h0);
		axiRd(sdstc_pkg::ADDR_HDAT1);
		chk("hdat1", rd, 32'h0);
		axiRd(sdstc_pkg::ADDR_STAT);
		chk("idle", rd & 32'hf, 32'h1);
		axiWr(sdstc_pkg::ADDR_VOL, 32'h00000080);
		axiRd(sdstc_pkg::ADDR_VOL);
		chk("volume", rd, 32'h80);
	endtask
	task automatic tSine();
		int n;
		axiWr(sdstc_pkg::ADDR_MODE, 32'h1);
		sendCmd({sdstc_pkg::CMD_SINE, 8'ha1, 32'h00000001});
		axiRd(sdstc_pkg::ADDR_STAT);
		chk("spoiled", rd & 32'hf, 32'h1);
		sendCmd({sdstc_pkg::CMD_SINE, 8'ha1, 32'h0});
		axiRd(sdstc_pkg::ADDR_STAT);
		chk("sine", rd & 32'hff0f, 32'ha108);
		waitStrobe();
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (audioOut.strobe !== 1'b1);
		chk("sine period", n, 32'd15625);
		chk("sine left", {16'h0, audioOut.left}, {16'h0, sdstc_pkg::SINE_Q[1]});
		chk("sine right", {16'h0, audioOut.right}, {16'h0, sdstc_pkg::SINE_Q[1] >> 1});
		sendCmd({sdstc_pkg::CMD_EXIT, 32'h0});
		axiRd(sdstc_pkg::ADDR_STAT);
		chk("exit", rd & 32'hf, 32'h1);
	endtask
	task automatic tWav();
		logic [7:0] fr [4] = '{8'h34, 8'h12, 8'h78, 8'h56};
		axiWr(sdstc_pkg::ADDR_MODE, 32'h0);
		sendHdr(sdstc_pkg::FMT_PCM, sdstc_pkg::CHAN_STEREO, 16'hbb80, sdstc_pkg::BITS_16);
		axiRd(sdstc_pkg::ADDR_HDAT0);
		chk("rate", rd, 32'hbb80);
		axiRd(sdstc_pkg::ADDR_HDAT1);
		chk("format", rd, 32'h1);
		foreach (fr[i]) i_host.sendByte(fr[i]);
		for (int i = 0; i < 3 && audioOut.left !== 16'h1234; i++) waitStrobe();
		chk("left", {16'h0, audioOut.left}, 32'h1234);
		chk("right", {16'h0, audioOut.right}, 32'h2b3c);
		axiRd(sdstc_pkg::ADDR_HDAT1);
		chk("endless", rd, 32'h1);
		axiWr(sdstc_pkg::ADDR_MODE, 32'h2);
		for (int i = 0; i < 50 && rd !== 32'h0; i++) axiRd(sdstc_pkg::ADDR_HDAT1);
		chk("aborted", rd, 32'h0);
		chk("muted", {31'h0, audioMute}, 32'h1);
	endtask
	task automatic tReset();
		int n;
		axiWr(sdstc_pkg::ADDR_MODE, 32'h4);
		do @(negedge mclk); while (dataRequest !== 1'b0);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (dataRequest !== 1'b1);
		chk("hold", {31'h0, n >= HOLD_SIM}, 32'h1);
		sendHdr(sdstc_pkg::FMT_ADPCM, 8'h01, 16'h1f3b, 8'h04);
		axiRd(sdstc_pkg::ADDR_HDAT0);
		chk("odd rate", rd, 32'h1f3b);
		axiRd(sdstc_pkg::ADDR_HDAT1);
		chk("adpcm", rd, 32'h11);
		axiWr(sdstc_pkg::ADDR_MODE, 32'h2);
		axiRd(sdstc_pkg::ADDR_STAT);
		chk("adpcm stopped", rd & 32'hf, 32'h1);
		sendCmd({sdstc_pkg::CMD_SINE, 8'ha1, 32'h0});
		axiRd(sdstc_pkg::ADDR_STAT);
		chk("as audio", rd & 32'hf, 32'h1);
	endtask
	initial begin
		mclk = 1'b0;
		srst = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		tRegs();
		tSine();
		tWav();
		tReset();
		conclude();
	end
	initial begin
		#400000;
		miscompares++;
		conclude();
	end
endmodule

/* verif/sdstc_host.sv */
// Host model that feeds bytes on the serial data link.
`timescale 1ns/1ps
module sdstc_host (
	// Clock and flow control
	input wire logic mclk,
	input wire logic dataRequest,
	// Serial data link
	output logic serialDataClk,
	output logic serialDataInput
);
	// ****
	// Byte sender
	// ****
	initial begin
		serialDataClk = 1'b0;
		serialDataInput = 1'b0;
	end
	task automatic sendByte(input logic [7:0] b);
		do @(negedge mclk); while (dataRequest !== 1'b1);
		@(posedge mclk);
		for (int i = 7; i >= 0; i--) begin
			serialDataInput <= b[i];
			repeat (20) @(posedge mclk);
			serialDataClk <= 1'b1;
			repeat (20) @(posedge mclk);
			serialDataClk <= 1'b0;
		end
		serialDataInput <= ~b[0];
	endtask
endmodule
